// ==== spi_scratch_defines.svh ====
// Shared constants of the parity/probe/scratch SPI link
`ifndef SPI_SCRATCH_DEFINES_SVH
`define SPI_SCRATCH_DEFINES_SVH
// ==========================================
// Device register addresses (command bits 13..9)
`define ADDR_PROBE 5'h00
`define ADDR_SCRATCH_A 5'h01
`define ADDR_SCRATCH_D 5'h04
// ==========================================
// Command field positions and codes
`define CMD_TOP_HI 15
`define CMD_TOP_LO 14
`define CMD_ADDR_HI 13
`define CMD_ADDR_LO 9
`define CMD_PARITY_BIT 8
`define CMD_SUB_BIT 7
`define CMD_CODE_READ 2'h0
`define CMD_CODE_WRITE 2'h1
`define CMD_BITS 5'h10
`define CMD_HALF 5'h08
// ==========================================
// Probe register fields, reset values and extended status codes
`define PROBE_SRC_HI 7
`define PROBE_SRC_LO 5
`define PROBE_RES_BIT 4
`define PROBE_ATT_BIT 3
`define PROBE_SRC_OFF 3'h0
`define PROBE_SRC_IO0 3'h4
`define PROBE_SRC_IO1 3'h5
`define PROBE_RESET 8'h00
`define SCRATCH_RESET 8'h00
`define EXT_STATUS_OK 8'h00
`define EXT_STATUS_PERR 8'h01
// ==========================================
// Host controller registers (Avalon byte addresses)
`define HOST_CTRL_ADDR 4'h0
`define HOST_CMD_ADDR 4'h4
`define HOST_STAT_ADDR 4'h8
`define HOST_RESP_ADDR 4'hC
`define HOST_CTRL_PAR_BIT 0
`define HOST_STAT_BUSY_BIT 0
// ==========================================
// Timing: clock 40 MHz, serial clock half period in ns and cycles
`define SYS_CLK_NS 25
`define SCLK_HALF_NS 200
`define SCLK_HALF_CYC (`SCLK_HALF_NS / `SYS_CLK_NS)
`endif

// ==== spi_scratch_pkg.sv ====
// Types and helpers used by the host end of the link
`default_nettype none
package spi_scratch_pkg;
    // ==========================================
    // Host sequencer states
    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_SETUP = 4'h2,
        H_SHIFT = 4'h4,
        H_DONE = 4'h8
    } host_state_type;

    typedef logic [15:0] cmd_word_type;

    // Bit 8 value that makes the whole word hold an odd count of ones
    function automatic logic odd_parity_bit(input logic [15:0] w);
        odd_parity_bit = ~(^{w[15:9], w[7:0]});
    endfunction
endpackage
`default_nettype wire

// ==== spi_scratch_if.sv ====
// Serial link between host controller and register device
`timescale 1ns/10ps
`default_nettype none
interface spi_scratch_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe_n;

    modport device (
        input sclk, cs_n, mosi,
        output miso, miso_oe_n
    );
    modport host (
        output sclk, cs_n, mosi,
        input miso, miso_oe_n
    );
endinterface
`default_nettype wire

// ==== spi_scratch_device.sv ====
// Device end: SPI slave with parity check, probe select and scratch registers
//
// Function
// - Parity applies only to write commands, top 01.
// - Count ones over bits 15-9 and 7-0.
// - Bit 8 makes total ones count odd.
// - Parity checked only when enable input set.
// - Host sends bit 8 zero when parity disabled.
// - Probe source 000 disables every probe source.
// - Source codes 001 to 111 select signals.
// - Probe bit 4 switches internal sense resistor.
// - Bit 3 attenuates, only for I/O sources.
// - Probe clears on reset, regulator off, non-Normal.
// - Probe access with regulator off ignored, clears.
// - Four scratch registers, addresses 1-4, reset only.
// - Write: 01, address 13-9, data low byte.
// - Read-back returns fixed status then register bits.
//
// Added by the designer: the Avalon-MM register port.
`include "spi_scratch_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module spi_scratch_device (
    input wire logic sys_clk_i,               // System clock, 40 MHz
    input wire logic reset_n_i,               // Power-on reset, active low
    spi_scratch_if.device link,               // Serial link pins
    input wire logic parity_en_i,             // Parity enable from init config
    input wire logic can_reg_on_i,            // CAN supply regulator on
    input wire logic normal_mode_i,           // Device in Normal mode
    input wire logic [7:0] fixed_status_i,    // Fixed status byte
    output logic [2:0] probe_source_o,        // Selected probe source
    output logic probe_enable_o,              // Probe output driven
    output logic sense_res_en_o,              // Internal sense resistor on
    output logic io_atten_o,                  // I/O attenuation active
    output logic parity_err_o                 // Pulse: write dropped on parity
);
    // ==========================================
    // Pin synchronisers
    logic [1:0] sclk_s_r;
    logic [1:0] cs_s_r;
    logic [1:0] mosi_s_r;
    logic sclk_d_r;
    logic cs_d_r;

    // Two flops per pin, then one delay stage for edges
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_s_r <= 2'h0;
            cs_s_r <= 2'h3;
            mosi_s_r <= 2'h0;
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end else begin
            sclk_s_r <= {sclk_s_r[0], link.sclk};
            cs_s_r <= {cs_s_r[0], link.cs_n};
            mosi_s_r <= {mosi_s_r[0], link.mosi};
            sclk_d_r <= sclk_s_r[1];
            cs_d_r <= cs_s_r[1];
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    // Edge detection on synchronised pins
    assign sclk_rise = sclk_s_r[1] & ~sclk_d_r & ~cs_s_r[1];
    assign sclk_fall = ~sclk_s_r[1] & sclk_d_r & ~cs_s_r[1];
    assign cs_fall = ~cs_s_r[1] & cs_d_r;
    assign cs_rise = cs_s_r[1] & ~cs_d_r;

    // ==========================================
    // Receive shifter and bit counter
    logic [15:0] rx_r;
    logic [4:0] cnt_r;
    logic [15:0] rx_nxt;

    assign rx_nxt = {rx_r[14:0], mosi_s_r[1]};

    // Shift in on rising serial clock
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_r <= 16'h0000;
            cnt_r <= 5'h00;
        end else if (cs_fall) begin
            cnt_r <= 5'h00;
        end else if (sclk_rise && cnt_r != `CMD_BITS) begin
            rx_r <= rx_nxt;
            cnt_r <= cnt_r + 5'h01;
        end
    end

    // ==========================================
    // Decode of the completed command
    logic [1:0] code;
    logic [4:0] addr;
    logic frame_ok;
    logic parity_ok;
    logic is_write;
    logic do_write;
    logic probe_live;

    assign code = rx_r[`CMD_TOP_HI:`CMD_TOP_LO];
    assign addr = rx_r[`CMD_ADDR_HI:`CMD_ADDR_LO];
    assign frame_ok = cs_rise && cnt_r == `CMD_BITS;
    assign is_write = code == `CMD_CODE_WRITE;
    assign parity_ok = !parity_en_i || (^rx_r);
    assign do_write = frame_ok && is_write && parity_ok;
    assign probe_live = can_reg_on_i && normal_mode_i;

    // ==========================================
    // Probe select register
    logic [7:0] probe_r;

    // Cleared whenever regulator is off or mode is not Normal
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            probe_r <= `PROBE_RESET;
        end else if (!probe_live) begin
            probe_r <= `PROBE_RESET;
        end else if (do_write && addr == `ADDR_PROBE) begin
            probe_r <= {rx_r[7:3], 3'h0};
        end
    end

    // ==========================================
    // Scratch registers, cleared by reset only
    logic [7:0] scratch_r [4];

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 4; i++) begin
                scratch_r[i] <= `SCRATCH_RESET;
            end
        end else if (do_write && addr >= `ADDR_SCRATCH_A && addr <= `ADDR_SCRATCH_D) begin
            scratch_r[2'(addr - `ADDR_SCRATCH_A)] <= rx_r[7:0];
        end
    end

    // ==========================================
    // Read-back content for the addressed register
    logic [7:0] rd_data;
    logic [4:0] rd_addr;

    assign rd_addr = rx_nxt[5:1];
    always_comb begin
        rd_data = 8'h00;
        if (rd_addr == `ADDR_PROBE) begin
            rd_data = probe_live ? probe_r : 8'h00;
        end else if (rd_addr >= `ADDR_SCRATCH_A && rd_addr <= `ADDR_SCRATCH_D) begin
            rd_data = scratch_r[2'(rd_addr - `ADDR_SCRATCH_A)];
        end
    end

    // ==========================================
    // Transmit shifter
    logic [15:0] tx_r;
    logic ext_perr_r;
    logic first_byte_read;

    // Top 00 and bit 8 set select register read-back
    assign first_byte_read = rx_nxt[7:6] == `CMD_CODE_READ && rx_nxt[0];

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_r <= 16'h0000;
        end else if (cs_fall) begin
            tx_r <= {fixed_status_i, ext_perr_r ? `EXT_STATUS_PERR : `EXT_STATUS_OK};
        end else if (sclk_rise && cnt_r == `CMD_HALF - 5'h01 && first_byte_read) begin
            tx_r[14:7] <= rd_data;
        end else if (sclk_fall) begin
            tx_r <= {tx_r[14:0], 1'b0};
        end
    end

    // Parity error of the last frame, if a write, shows in next extended status
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ext_perr_r <= 1'b0;
        end else if (frame_ok) begin
            ext_perr_r <= is_write && !parity_ok;
        end
    end

    // ==========================================
    // Registered outputs
    logic [2:0] src;

    assign src = probe_r[`PROBE_SRC_HI:`PROBE_SRC_LO];
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            probe_source_o <= `PROBE_SRC_OFF;
            probe_enable_o <= 1'b0;
            sense_res_en_o <= 1'b0;
            io_atten_o <= 1'b0;
            parity_err_o <= 1'b0;
        end else begin
            probe_source_o <= src;
            probe_enable_o <= src != `PROBE_SRC_OFF;
            sense_res_en_o <= probe_r[`PROBE_RES_BIT];
            io_atten_o <= probe_r[`PROBE_ATT_BIT]
                && (src == `PROBE_SRC_IO0 || src == `PROBE_SRC_IO1);
            parity_err_o <= frame_ok && is_write && !parity_ok;
        end
    end

    // Serial output pin, driven only while selected
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            link.miso <= 1'b0;
            link.miso_oe_n <= 1'b1;
        end else begin
            link.miso <= tx_r[15];
            link.miso_oe_n <= cs_s_r[1];
        end
    end

endmodule
`default_nettype wire

// ==== spi_scratch_host.sv ====
// Host end: Avalon-MM controlled SPI master that builds parity
`include "spi_scratch_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module spi_scratch_host #(
    parameter int SCLK_HALF = `SCLK_HALF_CYC  // Cycles per serial clock half
) (
    input wire logic sys_clk_i,               // System clock, 40 MHz
    input wire logic reset_n_i,               // Reset, active low
    spi_scratch_if.host link,                 // Serial link pins
    input wire logic [3:0] avs_address_i,     // Avalon byte address
    input wire logic avs_read_i,              // Avalon read
    input wire logic avs_write_i,             // Avalon write
    input wire logic [31:0] avs_writedata_i,  // Avalon write data
    output logic [31:0] avs_readdata_o,       // Avalon read data
    output logic avs_waitrequest_o            // Avalon wait request
);
    // ==========================================
    // Pin synchroniser for returned data
    logic [1:0] miso_s_r;
    logic [1:0] oe_s_r;
    logic miso_in;

    // Data and its enable both pass two flops
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            miso_s_r <= 2'h0;
            oe_s_r <= 2'h3;
        end else begin
            miso_s_r <= {miso_s_r[0], link.miso};
            oe_s_r <= {oe_s_r[0], link.miso_oe_n};
        end
    end

    // Released line reads as pulled high
    assign miso_in = oe_s_r[1] | miso_s_r[1];

    // ==========================================
    // Command word build
    logic par_en_r;
    logic [15:0] raw;
    logic [15:0] cmd_word;

    assign raw = avs_writedata_i[15:0];
    always_comb begin
        cmd_word = raw;
        if (raw[`CMD_TOP_HI:`CMD_TOP_LO] == `CMD_CODE_WRITE) begin
            cmd_word[`CMD_PARITY_BIT] = par_en_r
                ? spi_scratch_pkg::odd_parity_bit(raw) : 1'b0;
        end
    end

    // ==========================================
    // Bus slave: one wait cycle, or until idle for a command write, then a single-cycle answer
    spi_scratch_pkg::host_state_type state_r;
    logic req;
    logic busy;
    logic cmd_hit;
    logic accept;
    logic [15:0] resp_r;

    assign busy = state_r != spi_scratch_pkg::H_IDLE;
    assign req = avs_read_i || avs_write_i;
    assign cmd_hit = avs_write_i && avs_address_i == `HOST_CMD_ADDR;
    assign accept = req && avs_waitrequest_o && !(cmd_hit && busy);

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h00000000;
            par_en_r <= 1'b0;
        end else begin
            avs_waitrequest_o <= !accept;
            if (accept && avs_write_i && avs_address_i == `HOST_CTRL_ADDR) begin
                par_en_r <= avs_writedata_i[`HOST_CTRL_PAR_BIT];
            end
            if (accept && avs_read_i) begin
                unique case (avs_address_i)
                    `HOST_CTRL_ADDR: avs_readdata_o <= {31'h00000000, par_en_r};
                    `HOST_STAT_ADDR: avs_readdata_o <= {31'h00000000, busy};
                    `HOST_RESP_ADDR: avs_readdata_o <= {16'h0000, resp_r};
                    default: avs_readdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    // ==========================================
    // Serial sequencer
    logic [15:0] tx_r;
    logic [4:0] bit_r;
    logic [7:0] div_r;
    logic half_end;

    assign half_end = div_r == 8'(SCLK_HALF - 1);

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= spi_scratch_pkg::H_IDLE;
            tx_r <= 16'h0000;
            resp_r <= 16'h0000;
            bit_r <= 5'h00;
            div_r <= 8'h00;
            link.sclk <= 1'b0;
            link.cs_n <= 1'b1;
            link.mosi <= 1'b0;
        end else begin
            div_r <= half_end ? 8'h00 : div_r + 8'h01;
            unique case (state_r)
                spi_scratch_pkg::H_IDLE: begin
                    div_r <= 8'h00;
                    if (accept && cmd_hit) begin
                        tx_r <= cmd_word;
                        link.mosi <= cmd_word[15];
                        link.cs_n <= 1'b0;
                        bit_r <= 5'h00;
                        state_r <= spi_scratch_pkg::H_SETUP;
                    end
                end
                spi_scratch_pkg::H_SETUP: begin
                    if (half_end) begin
                        link.sclk <= 1'b1;
                        state_r <= spi_scratch_pkg::H_SHIFT;
                    end
                end
                spi_scratch_pkg::H_SHIFT: begin
                    if (half_end && link.sclk) begin
                        link.sclk <= 1'b0;
                        resp_r <= {resp_r[14:0], miso_in};
                        tx_r <= {tx_r[14:0], 1'b0};
                        link.mosi <= tx_r[14];
                        bit_r <= bit_r + 5'h01;
                        if (bit_r == `CMD_BITS - 5'h01) begin
                            state_r <= spi_scratch_pkg::H_DONE;
                        end
                    end else if (half_end) begin
                        link.sclk <= 1'b1;
                    end
                end
                spi_scratch_pkg::H_DONE: begin
                    if (half_end) begin
                        if (link.cs_n) begin
                            state_r <= spi_scratch_pkg::H_IDLE;
                        end
                        link.cs_n <= 1'b1;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== spi_scratch_link_properties.sv ====
// Link-level properties of the parity, probe and scratch serial link
`timescale 1ns/10ps
`default_nettype none
module spi_scratch_link_properties #(
    parameter int SCLK_HALF = 8  // Cycles per serial clock half
) (
    input wire logic sys_clk_i,  // System clock
    input wire logic reset_n_i,  // Reset, active low
    input wire logic sclk,       // Serial clock
    input wire logic cs_n,       // Select, active low
    input wire logic mosi,       // Host data
    input wire logic miso,       // Device data
    input wire logic miso_oe_n   // Device drives miso when low
);
    logic sclk_d_r;
    logic [15:0] lvl_cnt_r;
    logic [15:0] cs_lo_cnt_r;
    logic [4:0] rise_cnt_r;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    // ==========================================
    // Helper counters
    // Serial clock level and how long it has held
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_d_r <= 1'b0;
            lvl_cnt_r <= 16'h0000;
        end else begin
            sclk_d_r <= sclk;
            lvl_cnt_r <= (sclk != sclk_d_r) ? 16'h0001 : lvl_cnt_r + 16'h0001;
        end
    end

    // Cycles since select fell
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cs_lo_cnt_r <= 16'h0000;
        end else begin
            cs_lo_cnt_r <= cs_n ? 16'h0000 : cs_lo_cnt_r + 16'h0001;
        end
    end

    // Clock rises seen within the frame
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rise_cnt_r <= 5'h00;
        end else if (cs_n) begin
            rise_cnt_r <= 5'h00;
        end else if (sclk && !sclk_d_r) begin
            rise_cnt_r <= rise_cnt_r + 5'h01;
        end
    end

    // ==========================================
    // Sequences
    sequence s_idle_gap;
        (cs_n && !sclk) [*6];
    endsequence
    sequence s_released;
        ##[1:6] miso_oe_n;
    endsequence
    sequence s_driven;
        ##[1:6] !miso_oe_n;
    endsequence

    // ==========================================
    // Assertions
    AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
        else $error("serial clock active while deselected");
    AST_SETUP: assert property ($rose(sclk) |-> cs_lo_cnt_r >= SCLK_HALF)
        else $error("serial clock rose too soon after select");
    AST_HIGH_HALF: assert property ($fell(sclk) |-> lvl_cnt_r == SCLK_HALF)
        else $error("serial clock high half of wrong length");
    AST_FRAME_LEN: assert property ($rose(cs_n) |-> rise_cnt_r == 5'h10)
        else $error("frame without sixteen clock rises");
    AST_GAP: assert property ($rose(cs_n) |-> s_idle_gap)
        else $error("no idle gap after frame");
    AST_MOSI_STABLE: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("host data changed while clock high");
    AST_MISO_STABLE: assert property (sclk && $past(sclk) && !miso_oe_n |-> $stable(miso))
        else $error("device data changed while clock high");
    AST_MISO_RELEASE: assert property ($rose(cs_n) |-> s_released)
        else $error("device data line not released");
    AST_MISO_DRIVE: assert property ($fell(cs_n) |-> s_driven)
        else $error("device data line not driven in frame");
endmodule
`default_nettype wire

// ==== spi_parity_probe_scratch_regs_tb.sv ====
// Testbench for the parity, probe and scratch register link
`include "spi_scratch_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module spi_parity_probe_scratch_regs_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic par_en = 1'b0;
    logic reg_on = 1'b1;
    logic normal = 1'b1;
    logic [7:0] fstat = 8'hA5;
    logic [3:0] av_addr = 4'h0;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_wd = 32'h0;
    logic [31:0] av_q;
    logic [31:0] av_rdata;
    logic av_wait;
    logic [2:0] src;
    logic p_en, res_en, att, perr;
    logic [15:0] sniff = 16'h0;
    logic prev_drop = 1'b0;
    logic [7:0] pat [4] = '{8'h69, 8'h40, 8'hFF, 8'h80};
    int failures = 0;
    int num_checks = 0;
    int perr_cnt = 0;

    // ==========================================
    // Clock, link and design ends
    always #12.5 clk = ~clk;
    spi_scratch_if link();
    spi_scratch_device i_spi_scratch_device (.sys_clk_i(clk), .reset_n_i(rst_n), .link(link),
        .parity_en_i(par_en), .can_reg_on_i(reg_on), .normal_mode_i(normal),
        .fixed_status_i(fstat), .probe_source_o(src), .probe_enable_o(p_en),
        .sense_res_en_o(res_en), .io_atten_o(att), .parity_err_o(perr));
    spi_scratch_host i_spi_scratch_host (.sys_clk_i(clk), .reset_n_i(rst_n), .link(link),
        .avs_address_i(av_addr), .avs_read_i(av_rd), .avs_write_i(av_wr),
        .avs_writedata_i(av_wd), .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait));
    spi_scratch_link_properties #(.SCLK_HALF(`SCLK_HALF_CYC)) i_spi_scratch_link_properties (
        .sys_clk_i(clk), .reset_n_i(rst_n), .sclk(link.sclk), .cs_n(link.cs_n),
        .mosi(link.mosi), .miso(link.miso), .miso_oe_n(link.miso_oe_n));

    // Wire sniffer and dropped-write pulse count
    always @(posedge link.sclk) sniff <= {sniff[14:0], link.mosi};
    always @(posedge clk) if (perr === 1'b1) perr_cnt++;

    // ==========================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        av_addr <= a;
        av_wd <= d;
        av_wr <= wr;
        av_rd <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (av_wait !== 1'b0 && n < 100);
        if (n >= 100) failures++;
        av_q = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
        @(posedge clk);
    endtask

    // Send one command, wait for the end, compare wire word and answer
    task automatic frame(input logic [15:0] cmd, input logic [15:0] wexp, input logic [15:0] rexp);
        int n;
        n = 0;
        av(1'b1, `HOST_CMD_ADDR, {16'h0000, cmd});
        do begin
            av(1'b0, `HOST_STAT_ADDR, 32'h0);
            n++;
        end while (av_q[0] !== 1'b0 && n < 200);
        if (n >= 200) failures++;
        repeat (8) @(posedge clk);
        chk({16'h0000, sniff}, {16'h0000, wexp});
        av(1'b0, `HOST_RESP_ADDR, 32'h0);
        chk({16'h0000, av_q[15:0]}, {16'h0000, rexp});
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d, input logic par,
                          input logic drop);
        logic [15:0] c;
        c = {2'b01, a, 1'b0, d};
        if (par) c[8] = ~(^{c[15:9], c[7:0]});
        frame({2'b01, a, 1'b0, d}, c, {fstat, 7'h00, prev_drop});
        prev_drop = drop;
    endtask

    task automatic rd_reg(input logic [4:0] a, input logic [7:0] exp);
        frame({2'b00, a, 9'h100}, {2'b00, a, 9'h100}, {fstat, exp});
        prev_drop = 1'b0;
    endtask

    task automatic summarize;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++) rd_reg(i[4:0], 8'h00);
        par_en <= 1'b1;
        av(1'b1, `HOST_CTRL_ADDR, 32'h1);
        frame(16'h4669, 16'h4669, 16'hA500);
        frame(16'h4640, 16'h4740, 16'hA500);
        for (int i = 1; i < 5; i++) wr_reg(i[4:0], pat[i-1], 1'b1, 1'b0);
        fstat <= 8'h5A;
        @(posedge clk);
        for (int i = 1; i < 5; i++) rd_reg(i[4:0], pat[i-1]);
        av(1'b1, `HOST_CTRL_ADDR, 32'h0);
        wr_reg(5'h01, 8'h03, 1'b0, 1'b1);
        chk(32'(perr_cnt), 32'h1);
        rd_reg(5'h01, pat[0]);
        wr_reg(5'h01, 8'h07, 1'b0, 1'b0);
        rd_reg(5'h01, 8'h07);
        par_en <= 1'b0;
        wr_reg(5'h02, 8'h03, 1'b0, 1'b0);
        rd_reg(5'h02, 8'h03);
        chk(32'(perr_cnt), 32'h1);
        for (int i = 0; i < 8; i++) begin
            wr_reg(5'h00, {i[2:0], i[0], ~i[1], 3'h0}, 1'b0, 1'b0);
            chk({29'h0, src}, i);
            chk({31'h0, p_en}, {31'h0, i != 0});
            chk({31'h0, res_en}, {31'h0, i[0]});
            chk({31'h0, att}, {31'h0, ~i[1] && (i == 4 || i == 5)});
            rd_reg(5'h00, {i[2:0], i[0], ~i[1], 3'h0});
        end
        normal <= 1'b0;
        repeat (4) @(posedge clk);
        chk({27'h0, src, p_en, res_en}, 32'h0);
        normal <= 1'b1;
        rd_reg(5'h00, 8'h00);
        wr_reg(5'h00, 8'hE0, 1'b0, 1'b0);
        chk({29'h0, src}, 32'h7);
        reg_on <= 1'b0;
        repeat (4) @(posedge clk);
        chk({29'h0, src}, 32'h0);
        wr_reg(5'h00, 8'hA0, 1'b0, 1'b0);
        chk({29'h0, src}, 32'h0);
        reg_on <= 1'b1;
        rd_reg(5'h00, 8'h00);
        rd_reg(5'h03, pat[2]);
        summarize();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #1000000;
        failures++;
        summarize();
    end
endmodule
`default_nettype wire
